// ===== verilog/tep_consts.vh
// constants for the hot event pin and fan full_speed_on_event block
// assumes a 25 MHz core clock and 8-bit register accesses
`ifndef TEP_CONSTS_VH
`define TEP_CONSTS_VH

// ====================================================
// register offsets
`define TEP_REG_R1_CFG     8'h5f
`define TEP_REG_LOC_CFG    8'h60
`define TEP_REG_R2_CFG     8'h61
`define TEP_REG_R1_CRIT    8'h6a
`define TEP_REG_LOC_CRIT   8'h6b
`define TEP_REG_R2_CRIT    8'h6c
`define TEP_REG_STATUS2    8'h42
`define TEP_REG_MASK2      8'h75
`define TEP_REG_CFG3       8'h78
`define TEP_REG_TIMER      8'h79
`define TEP_REG_LIMIT      8'h7a

// ====================================================
// field positions
`define TEP_CH_OUT_EN_BIT  3
`define TEP_CFG3_FUNC_BIT  1
`define TEP_CFG3_FULL_SPEED_ON_EVENT_BIT 2
`define TEP_FLAG_BIT       5

// ====================================================
// reset values
`define TEP_RST_CH_CFG     8'h00
`define TEP_RST_CRIT       8'h00
`define TEP_RST_MASK2      8'h00
`define TEP_RST_CFG3       8'h00
`define TEP_RST_LIMIT      8'h00

// ====================================================
// timing
`define TEP_CLK_PERIOD_NS  40
`define TEP_TIMER_LSB_NS   22760000
`define TEP_TIMER_LSB_CYC  (`TEP_TIMER_LSB_NS / `TEP_CLK_PERIOD_NS)
`define TEP_PWM_DIV_CYC    16
`define TEP_DUTY_FULL      8'hff

`endif

// ===== verilog/tep_pwm.v
// one pwm fan drive channel with full-speed override
// assumes duty and full_speed_on_event come from logic on the same clock
`timescale 1ns/10ps
`include "tep_consts.vh"

module tep_pwm
#(
  parameter DIV_CYC = `TEP_PWM_DIV_CYC
)
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] duty,
  input  wire       full_speed_on_event,
  output reg        pwm_out
);

  reg [15:0] div_r;
  reg        tick_r;
  reg [7:0]  cnt_r;

  // ==================================================
  // slot divider, one enable pulse per pwm step
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (div_r == DIV_CYC[15:0] - 16'h0001)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ==================================================
  // period counter, 255 steps so full duty has no low slot
  always @(posedge clk)
  begin
    if (!rst_n)
      cnt_r <= 8'h00;
    else if (tick_r)
      cnt_r <= (cnt_r == 8'hfe) ? 8'h00 : cnt_r + 8'h01;
  end

  // ==================================================
  // duty compare; full_speed_on_event only lifts a fan already running
  always @(posedge clk)
  begin
    if (!rst_n)
      pwm_out <= 1'b0;
    else if (full_speed_on_event && duty != 8'h00)
      pwm_out <= 1'b1;
    else
      pwm_out <= (cnt_r < duty);
  end

endmodule // tep_pwm

// ===== verilog/tep_top.v
// hot event pin timing, alert flag, pin output drive and fan full_speed_on_event
// assumes a register port from the serial engine on the same clock,
// temperatures and monitor strobe from the conversion logic
//
// Function
// - full_speed_on_event bit set forces running fans to full duty while pin asserted
// - full_speed_on_event bit clear leaves fan duty untouched by pin events
// - mask bit 5 suppresses the alert for an exceeded event limit
// - event limit zero alerts on the very first pin assertion
// - enabled channel above critical limit by a quarter degree drives pin low
// - pin stays low while still above limit, releases at or below
// - driven assertion lasts at least one whole monitoring cycle
// - critical limits live at 0x6a, 0x6b, 0x6c per channel
// - bit 3 of 0x5f, 0x60, 0x61 enables pin drive per channel
// - fan speed set by pwm square wave duty on each output
// - four speed pulse inputs, three drives; fourth fan shares third drive
// - event timer accumulates, clears on read, holds at full scale
// - bit 0 on first assertion, then lsb worth 22.76 ms past 45.52 ms
// - timer above limit sets status flag and alert unless masked
// - config 3 bit 1 selects pin function and enables monitoring
`timescale 1ns/10ps
`include "tep_consts.vh"

module tep_top
#(
  parameter LSB_CYC = `TEP_TIMER_LSB_CYC,
  parameter PWM_DIV = `TEP_PWM_DIV_CYC
)
(
  input  wire       CLK,
  input  wire       RSTN,
  input  wire [7:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  input  wire       REG_WR,
  input  wire       REG_RD,
  output reg  [7:0] REG_RDATA,
  input  wire [9:0] TEMP_R1,
  input  wire [9:0] TEMP_LOC,
  input  wire [9:0] TEMP_R2,
  input  wire       MON_DONE,
  input  wire [7:0] DUTY1,
  input  wire [7:0] DUTY2,
  input  wire [7:0] DUTY3,
  input  wire       HOT_EVENT_PIN_IN,
  output reg        HOT_EVENT_PIN_OUT,
  output reg        HOT_EVENT_PIN_OE_N,
  input  wire [2:0] FAN_SPEED_PULSE_INPUT,
  output reg  [3:0] FAN_PULSE_SYNC,
  output wire       FAN1_DRIVE,
  output wire       FAN2_DRIVE,
  output wire       THIRD_FAN_DRIVE,
  output reg        SMBALERT_N
);

  // ==================================================
  // registers
  reg [7:0]  ch_cfg_r [0:2];
  reg [7:0]  crit_r   [0:2];
  reg [7:0]  mask2_r;
  reg [7:0]  cfg3_r;
  reg [7:0]  limit_r;
  reg        flag_r;
  reg [7:0]  units_r;
  reg        seen_r;
  reg [31:0] pre_r;
  reg [2:0]  over_r;
  reg        drive_r;
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg [2:0]  fan_speed_pulse_input_s1_r;
  reg [2:0]  fan_speed_pulse_input_s2_r;
  reg [7:0]  rd_nxt;

  wire [9:0] temp [0:2];
  wire       func_en  = cfg3_r[`TEP_CFG3_FUNC_BIT];
  wire       full_speed_on_event_en = cfg3_r[`TEP_CFG3_FULL_SPEED_ON_EVENT_BIT];
  wire       asserted = func_en & ~pin_s2_r;
  wire       timer_rd = REG_RD && (REG_ADDR == `TEP_REG_TIMER);
  wire       stat_rd  = REG_RD && (REG_ADDR == `TEP_REG_STATUS2);
  wire [7:0] timer_val;
  wire       full_speed_on_event_now = full_speed_on_event_en & asserted;

  assign temp[0] = TEMP_R1;
  assign temp[1] = TEMP_LOC;
  assign temp[2] = TEMP_R2;

  // below 45.52 ms only the first-assertion marker shows
  assign timer_val = (units_r >= 8'h02) ? units_r
                                        : {7'h00, seen_r};

  // ==================================================
  // two-stage synchronisers for the pin and speed pulses
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      fan_speed_pulse_input_s1_r <= 3'h0;
      fan_speed_pulse_input_s2_r <= 3'h0;
    end
    else
    begin
      pin_s1_r  <= HOT_EVENT_PIN_IN;
      pin_s2_r  <= pin_s1_r;
      fan_speed_pulse_input_s1_r <= FAN_SPEED_PULSE_INPUT;
      fan_speed_pulse_input_s2_r <= fan_speed_pulse_input_s1_r;
    end
  end

  // ==================================================
  // speed pulses to the measurement logic; the fourth shares the
  // event pin and is blanked once that pin serves as event input
  always @(posedge CLK)
  begin
    if (!RSTN)
      FAN_PULSE_SYNC <= 4'h0;
    else
      FAN_PULSE_SYNC <= {pin_s2_r & ~func_en, fan_speed_pulse_input_s2_r};
  end

  // ==================================================
  // per channel over-limit state, re-judged once per monitor cycle
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ch
      always @(posedge CLK)
      begin
        if (!RSTN)
          over_r[g] <= 1'b0;
        else if (MON_DONE)
          // quarter degree above means strictly above limit.00
          over_r[g] <= ch_cfg_r[g][`TEP_CH_OUT_EN_BIT] &&
                       (temp[g] > {crit_r[g], 2'b00});
      end
    end
  endgenerate

  // ==================================================
  // open-drain drive; over_r only moves at monitor strobes, so a
  // trip holds for a full monitoring cycle with no gap at the
  // strobe, and a continuing trip keeps the pin low throughout
  always @(posedge CLK)
  begin
    if (!RSTN)
      drive_r <= 1'b0;
    else
      drive_r <= func_en & (|over_r);
  end

  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      HOT_EVENT_PIN_OUT  <= 1'b0;
      HOT_EVENT_PIN_OE_N <= 1'b1;
    end
    else
    begin
      HOT_EVENT_PIN_OUT  <= 1'b0;
      HOT_EVENT_PIN_OE_N <= ~drive_r;
    end
  end

  // ==================================================
  // assertion time prescaler; wide so long lsb times still fit
  always @(posedge CLK)
  begin
    if (!RSTN || timer_rd)
      pre_r <= 32'h0;
    else if (asserted && units_r != 8'hff)
    begin
      if (pre_r == LSB_CYC - 1)
        pre_r <= 32'h0;
      else
        pre_r <= pre_r + 32'h1;
    end
  end

  // ==================================================
  // cumulative units with saturation; read restarts from zero
  always @(posedge CLK)
  begin
    if (!RSTN || timer_rd)
    begin
      units_r <= 8'h00;
      seen_r  <= 1'b0;
    end
    else
    begin
      if (asserted)
        seen_r <= 1'b1;
      if (asserted && units_r != 8'hff && pre_r == LSB_CYC - 1)
        units_r <= units_r + 8'h01;
    end
  end

  // ==================================================
  // status flag: set beats the read clear in the same cycle
  always @(posedge CLK)
  begin
    if (!RSTN)
      flag_r <= 1'b0;
    else if (timer_val > limit_r)
      flag_r <= 1'b1;
    else if (stat_rd)
      flag_r <= 1'b0;
  end

  // alert follows the flag; mask leaves the flag itself alone
  always @(posedge CLK)
  begin
    if (!RSTN)
      SMBALERT_N <= 1'b1;
    else
      SMBALERT_N <= ~(flag_r & ~mask2_r[`TEP_FLAG_BIT]);
  end

  // ==================================================
  // register writes
  integer i;
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        ch_cfg_r[i] <= `TEP_RST_CH_CFG;
        crit_r[i]   <= `TEP_RST_CRIT;
      end
      mask2_r <= `TEP_RST_MASK2;
      cfg3_r  <= `TEP_RST_CFG3;
      limit_r <= `TEP_RST_LIMIT;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        `TEP_REG_R1_CFG:   ch_cfg_r[0] <= REG_WDATA;
        `TEP_REG_LOC_CFG:  ch_cfg_r[1] <= REG_WDATA;
        `TEP_REG_R2_CFG:   ch_cfg_r[2] <= REG_WDATA;
        `TEP_REG_R1_CRIT:  crit_r[0]   <= REG_WDATA;
        `TEP_REG_LOC_CRIT: crit_r[1]   <= REG_WDATA;
        `TEP_REG_R2_CRIT:  crit_r[2]   <= REG_WDATA;
        `TEP_REG_MASK2:    mask2_r     <= REG_WDATA;
        `TEP_REG_CFG3:     cfg3_r      <= REG_WDATA;
        `TEP_REG_LIMIT:    limit_r     <= REG_WDATA;
        default:           limit_r     <= limit_r;
      endcase
    end
  end

  // ==================================================
  // read mux; unmapped offsets read zero
  always @*
  begin
    case (REG_ADDR)
      `TEP_REG_R1_CFG:   rd_nxt = ch_cfg_r[0];
      `TEP_REG_LOC_CFG:  rd_nxt = ch_cfg_r[1];
      `TEP_REG_R2_CFG:   rd_nxt = ch_cfg_r[2];
      `TEP_REG_R1_CRIT:  rd_nxt = crit_r[0];
      `TEP_REG_LOC_CRIT: rd_nxt = crit_r[1];
      `TEP_REG_R2_CRIT:  rd_nxt = crit_r[2];
      `TEP_REG_MASK2:    rd_nxt = mask2_r;
      `TEP_REG_CFG3:     rd_nxt = cfg3_r;
      `TEP_REG_LIMIT:    rd_nxt = limit_r;
      `TEP_REG_TIMER:    rd_nxt = timer_val;
      `TEP_REG_STATUS2:  rd_nxt = {2'b00, flag_r, 5'h00};
      default:           rd_nxt = 8'h00;
    endcase
  end

  always @(posedge CLK)
  begin
    if (!RSTN)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
      REG_RDATA <= rd_nxt;
  end

  // ==================================================
  // three fan drives; full_speed_on_event reaches all of them together
  tep_pwm #(.DIV_CYC(PWM_DIV)) u_pwm1
  (
    .clk     (CLK),
    .rst_n   (RSTN),
    .duty    (DUTY1),
    .full_speed_on_event   (full_speed_on_event_now),
    .pwm_out (FAN1_DRIVE)
  );

  tep_pwm #(.DIV_CYC(PWM_DIV)) u_pwm2
  (
    .clk     (CLK),
    .rst_n   (RSTN),
    .duty    (DUTY2),
    .full_speed_on_event   (full_speed_on_event_now),
    .pwm_out (FAN2_DRIVE)
  );

  tep_pwm #(.DIV_CYC(PWM_DIV)) u_third_fan_drive
  (
    .clk     (CLK),
    .rst_n   (RSTN),
    .duty    (DUTY3),
    .full_speed_on_event   (full_speed_on_event_now),
    .pwm_out (THIRD_FAN_DRIVE)
  );

endmodule // tep_top

// ===== tb/tep_properties.sv
// checker for the hot event pin block, bound to tep_top
// assumes monitoring strobes at least 10 cycles apart
`timescale 1ns/10ps

// ==========================================
// properties
module tep_props
(
  input wire       CLK,
  input wire       RSTN,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire       REG_WR,
  input wire       REG_RD,
  input wire [7:0] REG_RDATA,
  input wire [9:0] TEMP_R1,
  input wire       MON_DONE,
  input wire [7:0] DUTY1,
  input wire       HOT_EVENT_PIN_IN,
  input wire       HOT_EVENT_PIN_OUT,
  input wire       HOT_EVENT_PIN_OE_N,
  input wire       FAN1_DRIVE,
  input wire       SMBALERT_N
);
  reg [7:0] cfg3_r, mask_r, lim_r, crit_r;
  reg       en_r;

  // mirror of writes, since the design's copies are hidden
  always @(posedge CLK)
    if (!RSTN)
    begin
      cfg3_r <= 8'h00;
      mask_r <= 8'h00;
      lim_r  <= 8'h00;
      crit_r <= 8'h00;
      en_r   <= 1'b0;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == 8'h78) cfg3_r <= REG_WDATA;
      if (REG_ADDR == 8'h75) mask_r <= REG_WDATA;
      if (REG_ADDR == 8'h7a) lim_r  <= REG_WDATA;
      if (REG_ADDR == 8'h6a) crit_r <= REG_WDATA;
      if (REG_ADDR == 8'h5f) en_r   <= REG_WDATA[3];
    end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // pin held low with full_speed_on_event armed and the fan running
  sequence full_speed_on_event_held;
    (!HOT_EVENT_PIN_IN && cfg3_r[2:1] == 2'b11 && DUTY1 != 8'h00)[*5];
  endsequence
  // pin held low, zero limit, unmasked; a read could clear the flag
  sequence first_event;
    (!HOT_EVENT_PIN_IN && !REG_RD && cfg3_r[1] && lim_r == 8'h00
     && !mask_r[5])[*8];
  endsequence

  pin_low_only_a: assert property (!HOT_EVENT_PIN_OUT)
    else $error("pin driven high");
  full_speed_on_event_full_a: assert property (full_speed_on_event_held |-> FAN1_DRIVE)
    else $error("full_speed_on_event missing");
  duty_off_a: assert property
    ((DUTY1 == 8'h00)[*3] |-> !FAN1_DRIVE)
    else $error("idle fan driven");
  alert_mask_a: assert property
    (mask_r[5] && $past(mask_r[5]) |-> SMBALERT_N)
    else $error("masked alert seen");
  first_alert_a: assert property (first_event |-> !SMBALERT_N)
    else $error("no alert on first event");
  trip_drive_a: assert property
    (MON_DONE && en_r && cfg3_r[1] && TEMP_R1 > {crit_r, 2'b00}
     |-> ##[1:3] !HOT_EVENT_PIN_OE_N)
    else $error("trip not driven");
  trip_hold_a: assert property
    ($fell(HOT_EVENT_PIN_OE_N) |-> (!HOT_EVENT_PIN_OE_N)[*8])
    else $error("trip too short");
  reset_quiet_a: assert property
    (disable iff (1'b0) !RSTN |=> SMBALERT_N && HOT_EVENT_PIN_OE_N
     && REG_RDATA == 8'h00)
    else $error("outputs busy in reset");
endmodule // tep_props

bind tep_top tep_props tep_props_i
(
  .CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TEMP_R1(TEMP_R1), .MON_DONE(MON_DONE), .DUTY1(DUTY1),
  .HOT_EVENT_PIN_IN(HOT_EVENT_PIN_IN), .HOT_EVENT_PIN_OUT(HOT_EVENT_PIN_OUT),
  .HOT_EVENT_PIN_OE_N(HOT_EVENT_PIN_OE_N), .FAN1_DRIVE(FAN1_DRIVE),
  .SMBALERT_N(SMBALERT_N)
);

// ===== tb/tep_hot_src.sv
// model of the outside party that asserts the hot event pin
// assumes the bench builds the open-drain wire with a pull-up
`timescale 1ns/10ps

// ==========================================
// event source
module tep_hot_src
(
  input  wire clk,
  output reg  pull_low
);
  initial pull_low = 1'b0;

  // pull low for k cycles, then let the pull-up win
  task hold_low(input integer k);
    begin
      @(negedge clk);
      pull_low = 1'b1;
      repeat (k) @(negedge clk);
      pull_low = 1'b0;
    end
  endtask
endmodule // tep_hot_src

// ===== tb/tep_testbench.sv
// bench for tep_top: register tasks, event source, monitor strobe
// assumes tep_props is bound to tep_top
`timescale 1ns/10ps

// ==========================================
// testbench
module testbench;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg        mon = 1'b0;
  reg  [3:0] mcnt = 4'h0;
  reg  [9:0] t_r1 = 10'h000;
  reg  [7:0] duty = 8'h00;
  reg  [9:0] t_loc = 10'h000;
  reg  [2:0] fan_speed_pulse_input = 3'b000;
  wire [7:0] rdata;
  wire [3:0] fps;
  wire       oe_n, pin_out, fan1, fan2, fan3, alert_n, src_low;
  wire       pin = ~src_low & (oe_n | pin_out); // pull-up unless pulled
  integer    fails = 0;
  integer    tests_run = 0;
  integer    i, n;
  localparam [71:0] MAP = {8'h5f, 8'h60, 8'h61, 8'h6a, 8'h6b, 8'h6c,
    8'h75, 8'h78, 8'h7a};

  tep_top #(.LSB_CYC(8), .PWM_DIV(2)) tep_top_i
  (
    .CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TEMP_R1(t_r1),
    .TEMP_LOC(t_loc), .TEMP_R2(10'h000), .MON_DONE(mon),
    .DUTY1(duty), .DUTY2(duty), .DUTY3(duty),
    .HOT_EVENT_PIN_IN(pin), .HOT_EVENT_PIN_OUT(pin_out),
    .HOT_EVENT_PIN_OE_N(oe_n), .FAN_SPEED_PULSE_INPUT(fan_speed_pulse_input),
    .FAN_PULSE_SYNC(fps), .FAN1_DRIVE(fan1), .FAN2_DRIVE(fan2),
    .THIRD_FAN_DRIVE(fan3), .SMBALERT_N(alert_n)
  );
  tep_hot_src tep_hot_src_i (.clk(clk), .pull_low(src_low));

  // clock, and a monitoring strobe every 16 cycles
  initial forever #20 clk = ~clk;
  always @(negedge clk)
  begin
    mcnt <= mcnt + 4'h1;
    mon  <= (mcnt == 4'hf);
  end

  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
    end
  endtask
  task rd_chk(input string what, input [7:0] a, input [7:0] exp);
    begin
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk(what, exp, rdata);
    end
  endtask
  // extra cycles cover the input synchroniser lag
  task pulse(input integer k);
    begin
      tep_hot_src_i.hold_low(k);
      repeat (4) @(negedge clk);
    end
  endtask
  task wait_mon;
    begin
      @(posedge mon);
      repeat (8) @(negedge clk);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // run is about 3000 cycles
  initial
  begin
    #(40 * 12000);
    fails = fails + 1;
    final_report;
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    for (i = 0; i < 9; i = i + 1)
    begin
      rd_chk("reset", MAP[8*i +: 8], 8'h00);
      wr_reg(MAP[8*i +: 8], 8'ha5);
    end
    for (i = 0; i < 9; i = i + 1)
    begin
      rd_chk("rdback", MAP[8*i +: 8], 8'ha5);
      wr_reg(MAP[8*i +: 8], 8'h00);
    end
    wr_reg(8'h79, 8'h55);
    rd_chk("ro timer", 8'h79, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    $display("test regs done");
    wr_reg(8'h78, 8'h02);
    wr_reg(8'h7a, 8'h10);
    pulse(3);
    rd_chk("first", 8'h79, 8'h01);
    rd_chk("cleared", 8'h79, 8'h00);
    pulse(18);
    pulse(18);
    rd_chk("accum", 8'h79, 8'h04);
    pulse(2100);
    chk("alert", 8'h00, {7'h00, alert_n});
    rd_chk("sat", 8'h79, 8'hff);
    rd_chk("flag", 8'h42, 8'h20);
    rd_chk("flag clr", 8'h42, 8'h00);
    @(negedge clk);
    chk("alert off", 8'h01, {7'h00, alert_n});
    $display("test timer done");
    wr_reg(8'h7a, 8'h00);
    wr_reg(8'h75, 8'h20);
    pulse(12);
    chk("masked", 8'h01, {7'h00, alert_n});
    rd_chk("t12", 8'h79, 8'h01);
    rd_chk("flag0", 8'h42, 8'h20);
    wr_reg(8'h75, 8'h00);
    pulse(12);
    chk("alert0", 8'h00, {7'h00, alert_n});
    $display("test limit done");
    duty = 8'h10;
    wr_reg(8'h78, 8'h06);
    fork
      tep_hot_src_i.hold_low(40);
      begin
        repeat (20) @(negedge clk);
        chk("boost1", 8'h01, {7'h00, fan1});
        chk("boost2", 8'h01, {7'h00, fan2});
        chk("boost3", 8'h01, {7'h00, fan3});
      end
    join
    wr_reg(8'h78, 8'h02);
    repeat (4) @(negedge clk);
    n = 0;
    fork
      tep_hot_src_i.hold_low(520);
      repeat (510) @(negedge clk) n = n + fan1;
    join
    chk("no full_speed_on_event", 8'h20, n[7:0]);
    repeat (4) @(negedge clk);
    rd_chk("t total", 8'h79, 8'h47);
    $display("test full_speed_on_event done");
    wr_reg(8'h78, 8'h00);
    fan_speed_pulse_input = 3'b101;
    fork
      tep_hot_src_i.hold_low(12);
      begin
        repeat (8) @(negedge clk);
        chk("shared fan_speed_pulse_input", 8'h00, {7'h00, fps[3]});
      end
    join
    repeat (4) @(negedge clk);
    chk("fan_speed_pulse_input sync", 8'h0d, {4'h0, fps});
    rd_chk("no count", 8'h79, 8'h00);
    wr_reg(8'h78, 8'h02);
    wr_reg(8'h6a, 8'h32);
    wr_reg(8'h5f, 8'h08);
    t_r1 = {8'h32, 2'b01};
    wait_mon;
    chk("drive", 8'h00, {7'h00, pin});
    wait_mon;
    chk("stay", 8'h00, {7'h00, oe_n});
    t_r1 = {8'h32, 2'b00};
    wait_mon;
    chk("release", 8'h01, {7'h00, oe_n});
    t_r1 = 10'h3ff;
    wr_reg(8'h5f, 8'h00);
    wait_mon;
    chk("disabled", 8'h01, {7'h00, oe_n});
    wr_reg(8'h6b, 8'h20);
    wr_reg(8'h60, 8'h08);
    t_loc = {8'h20, 2'b01};
    wait_mon;
    chk("local", 8'h00, {7'h00, oe_n});
    chk("fan_speed_pulse_input blank", 8'h00, {7'h00, fps[3]});
    t_loc = 10'h000;
    wait_mon;
    chk("local off", 8'h01, {7'h00, oe_n});
    $display("test drive done");
    final_report;
  end
endmodule // testbench
